// >>> rtl/spc_serial_port.sv
// Serial port: control/data registers over AHB-Lite plus shift engines.
// Assumes baudTick is a 16x oversample pulse on clk for modes 1 and 3.
//
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module spc_serial_port
	import spc_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic baudTick,
	input wire logic rxdIn,
	output logic rxdOut,
	output logic rxdOe,
	output logic txdOut
);
	////////////////////////////////////////////////////////////////////////
	// Declarations
	logic modeLow_q, modeHigh_q, mpf_q, ren_q, tb8_q, rb8_q, ti_q, ri_q;
	logic feFlag_q, feSel_q;
	logic [7:0] rxBuf_q, hrdata_q;
	logic dpWr_q;
	logic [11:0] dpAddr_q;
	logic apTake, wrCommit, wrCtrl, wrData, wrPwr;
	spc_mode_t mode;
	logic rxS;
	logic qInReady, qOutValid, qPop;
	logic [7:0] qOutData;
	spc_tx_state_t txState_q;
	logic [10:0] txShift_q;
	logic [3:0] txBits_q, txTick_q, divCnt_q, pre;
	logic m0Rx_q, preWrap, tick, txBitEnd, txTiSet, m0RxDone;
	spc_rx_state_t rxState_q;
	logic [3:0] rxTick_q, rxCnt_q;
	logic [9:0] rxShift_q;
	logic rxDone, rxAccept, rxLoad;
	spc_rx_frame_t rxFrame;

	assign mode = spc_mode_t'({modeLow_q, modeHigh_q});

	////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave: zero-wait except data writes into a full queue
	assign apTake = hsel && htrans[1] && hready;
	assign hreadyout = !(dpWr_q && dpAddr_q == ADDR_DATA && !qInReady);
	assign hresp = 1'b0;
	assign hrdata = {24'h0, hrdata_q};
	assign wrCommit = dpWr_q && hreadyout;
	assign wrCtrl = wrCommit && dpAddr_q == ADDR_CTRL;
	assign wrData = wrCommit && dpAddr_q == ADDR_DATA;
	assign wrPwr = wrCommit && dpAddr_q == ADDR_PWR;

	// Address phase capture
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			dpWr_q <= 1'b0;
			dpAddr_q <= '0;
		end
		else if (hreadyout)
		begin
			dpWr_q <= apTake && hwrite;
			dpAddr_q <= haddr[11:0];
		end
	end

	// Read data registered at the address phase; unmapped reads zero
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			hrdata_q <= '0;
		else if (apTake && !hwrite)
		begin
			case (haddr[11:0])
				ADDR_CTRL: hrdata_q <= {feSel_q ? feFlag_q : modeLow_q, modeHigh_q, mpf_q,
					ren_q, tb8_q, rb8_q, ti_q, ri_q};
				ADDR_DATA: hrdata_q <= rxBuf_q;
				ADDR_PWR: hrdata_q <= {1'b0, feSel_q, 6'h0};
				default: hrdata_q <= '0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control register fields written by software only
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			modeLow_q <= CTRL_RST[B_MODE_LOW];
			modeHigh_q <= CTRL_RST[B_MODE_HIGH];
			mpf_q <= CTRL_RST[B_MPF];
			ren_q <= CTRL_RST[B_REN];
			tb8_q <= CTRL_RST[B_TB8];
			feSel_q <= PWR_RST[B_FE_SEL];
		end
		else
		begin
			if (wrCtrl)
			begin
				// Top bit lands in mode only when not acting as error flag
				if (!feSel_q)
					modeLow_q <= hwdata[B_MODE_LOW];
				modeHigh_q <= hwdata[B_MODE_HIGH];
				mpf_q <= hwdata[B_MPF];
				ren_q <= hwdata[B_REN];
				tb8_q <= hwdata[B_TB8];
			end
			if (wrPwr)
				feSel_q <= hwdata[B_FE_SEL];
		end
	end

	// Hardware-set flags: a set in the clearing cycle wins
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ti_q <= CTRL_RST[B_TI];
			ri_q <= CTRL_RST[B_RI];
			rb8_q <= CTRL_RST[B_RB8];
			feFlag_q <= 1'b0;
		end
		else
		begin
			ti_q <= txTiSet || (wrCtrl ? hwdata[B_TI] : ti_q);
			ri_q <= rxLoad || (wrCtrl ? hwdata[B_RI] : ri_q);
			if (rxDone && rxAccept && mode[1])
				rb8_q <= rxFrame.ninth;
			else if (rxDone && rxAccept && !mpf_q)
				rb8_q <= rxFrame.stopBit;
			else if (wrCtrl)
				rb8_q <= hwdata[B_RB8];
			feFlag_q <= (rxDone && feSel_q && !rxFrame.stopBit) ||
				((wrCtrl && feSel_q) ? hwdata[B_MODE_LOW] : feFlag_q);
		end
	end

	// Receive buffer; data writes never touch it
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			rxBuf_q <= DATA_RST;
		else if (rxLoad)
			// Sync receive: the last bit lands in the same edge, so take it from the pin
			rxBuf_q <= m0RxDone ? {rxS, txShift_q[7:1]} : rxFrame.data;
	end

	////////////////////////////////////////////////////////////////////////
	// Transmit queue; full queue stalls the bus write
	spc_fifo2 #(.W(TXQ_WIDTH), .D(TXQ_DEPTH)) uTxQ (
		.clk(clk),
		.resetn(resetn),
		.inValid(wrData),
		.inReady(qInReady),
		.inData(hwdata[7:0]),
		.outValid(qOutValid),
		.outReady(qPop),
		.outData(qOutData)
	);

	spc_sync3 uRxSync (
		.clk(clk),
		.resetn(resetn),
		.pinIn(rxdIn),
		.level(rxS)
	);

	////////////////////////////////////////////////////////////////////////
	// Rate select: sync mode /12 or /4, fixed 11-bit /64, else baudTick
	assign pre = (mode == MODE_SYNC) ? (mpf_q ? DIV_M0_FAST : DIV_M0_SLOW) : DIV_M2_TICK;
	assign preWrap = (divCnt_q == pre - 4'h1);
	assign tick = (mode == MODE_ASYNC10 || mode == MODE_VAR11) ? baudTick : preWrap;

	// Free-running prescaler
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			divCnt_q <= '0;
		else if (preWrap || divCnt_q >= pre)
			divCnt_q <= '0;
		else
			divCnt_q <= divCnt_q + 4'h1;
	end

	////////////////////////////////////////////////////////////////////////
	// Transmit engine, also runs sync-mode reception
	assign txBitEnd = (txState_q == TX_RUN) &&
		((mode == MODE_SYNC) ? preWrap : (tick && txTick_q == TICK_LAST));
	assign txTiSet = txBitEnd && !m0Rx_q &&
		(txBits_q == ((mode == MODE_SYNC) ? 4'h1 : 4'h2));
	assign m0RxDone = txBitEnd && m0Rx_q && txBits_q == 4'h1;
	assign qPop = (txState_q == TX_IDLE) && qOutValid;

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			txState_q <= TX_IDLE;
			txShift_q <= '1;
			txBits_q <= '0;
			txTick_q <= '0;
			m0Rx_q <= 1'b0;
		end
		else
		begin
			case (txState_q)
				TX_IDLE:
				begin
					txTick_q <= '0;
					if (qPop)
					begin
						txState_q <= TX_RUN;
						m0Rx_q <= 1'b0;
						// Frame LSB first: start, data, ninth or stop, stop; sync mode loads the data byte only
						case (mode)
							MODE_SYNC:
							begin
								txShift_q <= {3'h7, qOutData};
								txBits_q <= 4'h8;
							end
							MODE_ASYNC10:
							begin
								txShift_q <= {2'h3, qOutData, 1'b0};
								txBits_q <= 4'ha;
							end
							default:
							begin
								txShift_q <= {1'b1, tb8_q, qOutData, 1'b0};
								txBits_q <= 4'hb;
							end
						endcase
					end
					else if (mode == MODE_SYNC && ren_q && !ri_q)
					begin
						// Sync receive shares the shift clock
						txState_q <= TX_RUN;
						m0Rx_q <= 1'b1;
						txShift_q <= '1;
						txBits_q <= 4'h8;
					end
				end
				TX_RUN:
				begin
					if (mode != MODE_SYNC && tick)
						txTick_q <= txTick_q + 4'h1;
					if (txBitEnd)
					begin
						// Sync receive shifts the pin into bit 7; frames shift the whole word
						txShift_q <= m0Rx_q ? {3'h7, rxS, txShift_q[7:1]} : {1'b1, txShift_q[10:1]};
						txBits_q <= txBits_q - 4'h1;
						if (txBits_q == 4'h1)
							txState_q <= TX_IDLE;
					end
					if (m0Rx_q && !ren_q)
						txState_q <= TX_IDLE;
				end
				default: txState_q <= TX_IDLE;
			endcase
		end
	end

	// Pins: sync mode drives clock on txd and data on rxd
	always_comb
	begin
		rxdOe = (txState_q == TX_RUN) && (mode == MODE_SYNC) && !m0Rx_q;
		rxdOut = txShift_q[0];
		if (mode == MODE_SYNC)
			txdOut = !((txState_q == TX_RUN) && (divCnt_q < (pre >> 1)));
		else
			txdOut = (txState_q == TX_RUN) ? txShift_q[0] : 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// Asynchronous receive engine, mid-bit sampling
	assign rxDone = (rxState_q == RX_DATA) && tick && rxTick_q == TICK_LAST &&
		rxCnt_q == (mode[1] ? 4'h9 : 4'h8);
	always_comb
	begin
		rxFrame.stopBit = rxS;
		// Eleven-bit frames hold nine samples, ten-bit frames eight
		if (mode[1])
		begin
			rxFrame.data = rxShift_q[8:1];
			rxFrame.ninth = rxShift_q[9];
		end
		else
		begin
			rxFrame.data = rxShift_q[9:2];
			rxFrame.ninth = 1'b0;
		end
	end
	// Filter: 11-bit needs ninth set, 10-bit needs a good stop
	assign rxAccept = !mpf_q || (mode[1] ? rxFrame.ninth : rxFrame.stopBit);
	assign rxLoad = (rxDone && rxAccept) || m0RxDone;

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rxState_q <= RX_IDLE;
			rxTick_q <= '0;
			rxCnt_q <= '0;
			rxShift_q <= '0;
		end
		else if (!ren_q || mode == MODE_SYNC)
			rxState_q <= RX_IDLE;
		else
		begin
			if (tick)
				rxTick_q <= rxTick_q + 4'h1;
			case (rxState_q)
				RX_IDLE:
				begin
					rxTick_q <= '0;
					if (!rxS)
						rxState_q <= RX_START;
				end
				RX_START:
				begin
					// Glitch shorter than half a bit is dropped
					if (tick && rxTick_q == TICK_MID)
					begin
						rxState_q <= rxS ? RX_IDLE : RX_DATA;
						rxTick_q <= '0;
						rxCnt_q <= '0;
					end
				end
				RX_DATA:
				begin
					if (tick && rxTick_q == TICK_LAST)
					begin
						rxShift_q <= {rxS, rxShift_q[9:1]};
						rxCnt_q <= rxCnt_q + 4'h1;
						if (rxDone)
							rxState_q <= RX_IDLE;
					end
				end
				default: rxState_q <= RX_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	property p_tiAtStop;
		@(posedge clk) disable iff (!resetn)
		txBitEnd && !m0Rx_q && mode != MODE_SYNC && txBits_q == 4'h2 |=> ti_q && txShift_q[0];
	endproperty
	a_tiAtStop: assert property (p_tiAtStop) else $error("transmit flag late");
	property p_riLoad;
		@(posedge clk) disable iff (!resetn)
		rxDone && rxAccept |=> ri_q && rxBuf_q == $past(rxFrame.data);
	endproperty
	a_riLoad: assert property (p_riLoad) else $error("receive load wrong");
	property p_filt11;
		@(posedge clk) disable iff (!resetn)
		rxDone && mode[1] && mpf_q && !rxFrame.ninth && !wrCtrl |=> ri_q == $past(ri_q);
	endproperty
	a_filt11: assert property (p_filt11) else $error("ninth filter");
	property p_filt10;
		@(posedge clk) disable iff (!resetn)
		rxDone && mode == MODE_ASYNC10 && mpf_q && !rxS |=> $stable(rxBuf_q);
	endproperty
	a_filt10: assert property (p_filt10) else $error("stop filter");
	property p_fe;
		@(posedge clk) disable iff (!resetn)
		rxDone && feSel_q && !rxS |=> feFlag_q;
	endproperty
	a_fe: assert property (p_fe) else $error("frame error lost");
	property p_ren;
		@(posedge clk) disable iff (!resetn)
		!ren_q |=> rxState_q == RX_IDLE ##1 !rxLoad;
	endproperty
	a_ren: assert property (p_ren) else $error("receive while disabled");
	property p_wrKeepsRx;
		@(posedge clk) disable iff (!resetn)
		wrData && !rxLoad |=> $stable(rxBuf_q);
	endproperty
	a_wrKeepsRx: assert property (p_wrKeepsRx) else $error("write hit receive");
	property p_start;
		@(posedge clk) disable iff (!resetn)
		qPop |=> txState_q == TX_RUN && !m0Rx_q;
	endproperty
	a_start: assert property (p_start) else $error("no frame start");
	property p_ninthTx;
		@(posedge clk) disable iff (!resetn)
		qPop && mode[1] |=> txShift_q[9] == $past(tb8_q) && txBits_q == 4'hb;
	endproperty
	a_ninthTx: assert property (p_ninthTx) else $error("ninth bit wrong");
	property p_fast0;
		@(posedge clk) disable iff (!resetn)
		mode == MODE_SYNC && mpf_q && preWrap && !wrCtrl |=> !preWrap [*3] ##1 preWrap;
	endproperty
	a_fast0: assert property (p_fast0) else $error("sync divider");
	c_txFrame: cover property (@(posedge clk) txTiSet && mode != MODE_SYNC);
	c_rxOk: cover property (@(posedge clk) rxDone && rxAccept && mpf_q);
	c_syncRx: cover property (@(posedge clk) m0RxDone);
	c_stall: cover property (@(posedge clk) !hreadyout);
endmodule : spc_serial_port

// >>> common/spc_pkg.sv
// Serial port control package: register map, field positions, dividers, types.
// Assumes a single core clock and an AHB-Lite register path.
//
// Functional notes
// - Top control bit is mode or frame error
// - Bad stop bit sets sticky frame error
// - Two mode bits pick frame format, rate
// - 11-bit filter drops frames with ninth zero
// - 10-bit filter drops frames with bad stop
// - Sync mode: filter bit picks /12 or /4
// - Receive only while receive enable set
// - Ninth sent bit is software value
// - Ninth field captures ninth, or stop bit if filter bit clear
// - Transmit flag timing; software clears only
// - Receive flag timing, filtered; software clears
// - Data read is receive, write is transmit
package spc_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] CTRL_IDX = 8'h98;
	localparam logic [7:0] DATA_IDX = 8'h99;
	localparam logic [7:0] PWR_IDX = 8'h87;
	localparam logic [11:0] ADDR_CTRL = {2'h0, CTRL_IDX, 2'h0};
	localparam logic [11:0] ADDR_DATA = {2'h0, DATA_IDX, 2'h0};
	localparam logic [11:0] ADDR_PWR = {2'h0, PWR_IDX, 2'h0};
	// Control field positions
	localparam int B_MODE_LOW = 7;
	localparam int B_MODE_HIGH = 6;
	localparam int B_MPF = 5;
	localparam int B_REN = 4;
	localparam int B_TB8 = 3;
	localparam int B_RB8 = 2;
	localparam int B_TI = 1;
	localparam int B_RI = 0;
	localparam int B_FE_SEL = 6;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] PWR_RST = 8'h00;
	localparam logic [7:0] DATA_RST = 8'h00;
	// Dividers in core clocks
	localparam logic [3:0] DIV_M0_SLOW = 4'hc;
	localparam logic [3:0] DIV_M0_FAST = 4'h4;
	localparam logic [3:0] DIV_M2_TICK = 4'h4;
	localparam logic [3:0] TICK_LAST = 4'hf;
	localparam logic [3:0] TICK_MID = 4'h7;
	localparam int TXQ_DEPTH = 2;
	localparam int TXQ_WIDTH = 8;
	typedef enum logic [1:0] {
		MODE_SYNC = 2'h0,
		MODE_ASYNC10 = 2'h1,
		MODE_FIXED11 = 2'h2,
		MODE_VAR11 = 2'h3
	} spc_mode_t;
	typedef enum logic [1:0] {TX_IDLE = 2'h0, TX_RUN = 2'h1} spc_tx_state_t;
	typedef enum logic [1:0] {RX_IDLE = 2'h0, RX_START = 2'h1, RX_DATA = 2'h3} spc_rx_state_t;
	// One finished receive frame
	typedef struct packed {
		logic [7:0] data;
		logic ninth;
		logic stopBit;
	} spc_rx_frame_t;
endpackage : spc_pkg

// >>> rtl/spc_sync3.sv
// Three-flop input synchroniser with agreement filter.
// Assumes the input is asynchronous to clk.
`timescale 1ns/1ps
module spc_sync3
	import spc_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic pinIn,
	output logic level
);
	logic s1_q, s2_q, s3_q, level_q;
	// First stage feeds only the second stage
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			s1_q <= 1'b1;
			s2_q <= 1'b1;
			s3_q <= 1'b1;
		end
		else
		begin
			s1_q <= pinIn;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	// Change counts once stages two and three agree
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			level_q <= 1'b1;
		else if (s2_q == s3_q)
			level_q <= s3_q;
	end
	assign level = level_q;
endmodule : spc_sync3

// >>> rtl/spc_fifo2.sv
// Small valid/ready buffer for transmit bytes.
// Assumes both sides on clk; full and empty are exact.
`timescale 1ns/1ps
module spc_fifo2
	import spc_pkg::*;
#(
	parameter int W = TXQ_WIDTH,
	parameter int D = TXQ_DEPTH
)
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic inValid,
	output logic inReady,
	input wire logic [W-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [W-1:0] outData
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;
	logic [W-1:0] mem_q [D];
	logic [AW-1:0] wp_q, rp_q;
	logic [AW:0] cnt_q;
	logic push, pop;
	assign inReady = (cnt_q != (AW+1)'(D));
	assign outValid = (cnt_q != '0);
	assign push = inValid && inReady;
	assign pop = outValid && outReady;
	assign outData = mem_q[rp_q];
	// Pointers wrap at depth
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end
		else
		begin
			if (push)
				wp_q <= (wp_q == AW'(D-1)) ? '0 : wp_q + 1'b1;
			if (pop)
				rp_q <= (rp_q == AW'(D-1)) ? '0 : rp_q + 1'b1;
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
	// Storage in flops
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			for (int i = 0; i < D; i++)
				mem_q[i] <= '0;
		else if (push)
			mem_q[wp_q] <= inData;
	end
endmodule : spc_fifo2

// >>> verification/spc_far_node.sv
// Far serial node: drives frames into the port's receive pin and
// decodes the frames that the port sends. Assumes async framing,
// LSB first, a line that idles high and whole bit times in clocks.
`timescale 1ns/1ps
module spc_far_node
(
	input wire logic clk,
	input wire logic en,
	input wire logic nine,
	input wire logic [7:0] bitLen,
	input wire logic txd,
	output logic rxd,
	output logic got,
	output logic [9:0] frame
);
	////////////////////////////////////////////////////////////////////////////////
	// One frame out; stop can be forced low to model a broken frame
	task automatic send(input logic [7:0] d, input logic n, input logic s);
		logic [10:0] f;
		int i;
		begin
			f = nine ? {s, n, d, 1'b0} : {1'b1, s, d, 1'b0};
			for (i = 0; i < 10 + nine; i++)
			begin
				rxd <= f[i];
				repeat (bitLen) @(posedge clk);
			end
			// Back to mark level, the line is pulled high when idle
			rxd <= 1'b1;
		end
	endtask : send

	////////////////////////////////////////////////////////////////////////////////
	// Decoder: centre-samples each bit after a falling start edge
	initial
	begin
		logic [10:0] s;
		int i;
		rxd = 1'b1;
		got = 1'b0;
		frame = '0;
		forever
		begin
			@(posedge clk);
			got <= 1'b0;
			if (en && !txd)
			begin
				repeat (bitLen / 2) @(posedge clk);
				// Ends at stop centre so a back-to-back start is not missed
				for (i = 1; i < 10 + nine; i++)
				begin
					repeat (bitLen) @(posedge clk);
					s[i] = txd;
				end
				frame <= nine ? {s[10], s[9], s[8:1]} : {s[9], 1'b0, s[8:1]};
				got <= 1'b1;
			end
		end
	end
endmodule : spc_far_node

// >>> verification/spc_serial_port_bench.sv
// Bench for the serial port: AHB-Lite register traffic plus a far node.
// Assumes baudTick on every clock, so a bit in modes 1 and 3 lasts 16 clocks.
`timescale 1ns/1ps
module spc_serial_port_bench
	import spc_pkg::*;
;
	logic clk, resetn, hsel, hwrite, hreadyout, hresp, baudTick;
	logic rxdOut, rxdOe, txdOut, rxd, got, en, nine;
	logic [31:0] haddr, hwdata, hrdata, rv;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [9:0] frame;
	logic [7:0] ctrlNow, bitLen, lastRx, d;
	logic [9:0] txExp[$];
	logic [7:0] txModes[4] = '{8'h40, 8'hc8, 8'hc0, 8'h88};
	int num_errors, check_count, seed;

	// Node follows the selected mode: off in sync mode, /64 in mode 2
	assign en = ctrlNow[7:6] != 2'h0;
	assign nine = ctrlNow[7];
	assign bitLen = (ctrlNow[7:6] == 2'h2) ? 8'd64 : 8'd16;

	spc_serial_port dut (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.baudTick(baudTick), .rxdIn(rxd), .rxdOut(rxdOut), .rxdOe(rxdOe),
		.txdOut(txdOut));
	spc_far_node node (.clk(clk), .en(en), .nine(nine), .bitLen(bitLen),
		.txd(txdOut), .rxd(rxd), .got(got), .frame(frame));

	// 250 MHz core clock
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic end_sim();
		begin
			$display("checks %0d errors %0d", check_count, num_errors);
			if (num_errors == 0 && check_count > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask : end_sim

	task automatic check(input logic [31:0] act, input logic [31:0] exp);
		begin
			check_count++;
			if (act !== exp)
			begin
				num_errors++;
				$display("BAD %0t got %h want %h", $time, act, exp);
			end
		end
	endtask : check

	task automatic hang();
		begin
			num_errors++;
			$display("BAD %0t wait ran out", $time);
			end_sim();
		end
	endtask : hang

	// Waits for hready high at an edge; a stalled queue may hold it low
	task automatic waitRdy();
		int n;
		begin
			n = 0;
			@(posedge clk);
			while (hreadyout !== 1'b1 && n < 5000)
			begin
				@(posedge clk);
				n++;
			end
			if (n >= 5000)
				hang();
		end
	endtask : waitRdy

	// One single word transfer: address phase, then data phase
	task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] v);
		begin
			hsel <= 1'b1;
			haddr <= {20'h0, a};
			htrans <= 2'h2;
			hwrite <= w;
			waitRdy();
			hsel <= 1'b0;
			htrans <= 2'h0;
			hwdata <= {24'h0, v};
			waitRdy();
			rv = hrdata;
			check({31'h0, hresp}, 32'h0);
			@(posedge clk);
		end
	endtask : bus

	task automatic wr(input logic [11:0] a, input logic [7:0] v);
		bus(1'b1, a, v);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		begin
			bus(1'b0, a, 8'h00);
			check(rv, {24'h0, e});
		end
	endtask : rd

	// Sender notes the frame the node should decode, then writes it
	task automatic txw(input logic [7:0] v);
		begin
			txExp.push_back({1'b1, ctrlNow[7] & ctrlNow[3], v});
			wr(ADDR_DATA, v);
		end
	endtask : txw

	task automatic drainTx();
		int n;
		begin
			for (n = 0; n < 20000 && txExp.size() != 0; n++)
				@(posedge clk);
			if (txExp.size() != 0)
				hang();
		end
	endtask : drainTx

	// Node sends one frame; flags, ninth bit and buffer are then read
	task automatic rxCase(input logic [7:0] c, input logic n, input logic s,
		input logic [7:0] e);
		begin
			ctrlNow = c;
			wr(ADDR_CTRL, c);
			d = 8'($random(seed));
			node.send(d, n, s);
			repeat (16) @(posedge clk);
			rd(ADDR_CTRL, e);
			if (e[0])
				lastRx = d;
			rd(ADDR_DATA, lastRx);
		end
	endtask : rxCase

	// Shift clock period in sync mode, from one falling edge to the next
	task automatic syncCase(input logic [7:0] c, input int e);
		int n, k;
		logic p;
		begin
			ctrlNow = c;
			wr(ADDR_CTRL, c);
			wr(ADDR_DATA, 8'($random(seed)));
			// First fall may be a short first bit, so measure the third
			for (k = 0; k < 3; k++)
			begin
				n = 0;
				do
				begin
					p = txdOut;
					@(posedge clk);
					n++;
				end
				while (!(p && !txdOut) && n < 200);
			end
			check(n, e);
			check({31'h0, rxdOe}, 32'h1);
			repeat (8 * e) @(posedge clk);
			check({30'h0, rxdOe, rxdOut}, 32'h1);
			rd(ADDR_CTRL, c | 8'h02);
		end
	endtask : syncCase

	////////////////////////////////////////////////////////////////////////////////
	// Watcher: each decoded frame takes the oldest note off the queue
	always @(posedge clk)
	begin
		if (got === 1'b1)
		begin
			if (txExp.size() == 0)
				check(32'h1, 32'h0);
			else
				check({22'h0, frame}, {22'h0, txExp.pop_front()});
		end
	end

	// Main sequence
	initial
	begin
		seed = 32'hbdcb8a02;
		num_errors = 0;
		check_count = 0;
		resetn = 1'b0;
		hsel = 1'b0;
		haddr = '0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = '0;
		baudTick = 1'b0;
		ctrlNow = 8'h00;
		lastRx = DATA_RST;
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		baudTick <= 1'b1;
		rd(ADDR_CTRL, CTRL_RST);
		rd(ADDR_DATA, DATA_RST);
		rd(ADDR_PWR, PWR_RST);
		// Unmapped place ignores writes and reads zero
		wr(12'h100, 8'hff);
		rd(12'h100, 8'h00);
		// Three back-to-back bytes per async mode fill the queue
		foreach (txModes[i])
		begin
			ctrlNow = txModes[i];
			wr(ADDR_CTRL, ctrlNow);
			repeat (3) txw(8'($random(seed)));
			drainTx();
			rd(ADDR_CTRL, ctrlNow | 8'h02);
		end
		syncCase(8'h00, 12);
		syncCase(8'h20, 4);
		// Sync receive with an idle line fills the buffer with ones
		wr(ADDR_CTRL, 8'h30);
		repeat (64) @(posedge clk);
		rd(ADDR_CTRL, 8'h31);
		lastRx = 8'hff;
		rd(ADDR_DATA, lastRx);
		rxCase(8'h50, 1'b0, 1'b1, 8'h55);
		txw(8'($random(seed)));
		drainTx();
		rd(ADDR_DATA, lastRx);
		rxCase(8'h40, 1'b1, 1'b1, 8'h40);
		rxCase(8'hd0, 1'b0, 1'b1, 8'hd1);
		rxCase(8'hf0, 1'b0, 1'b1, 8'hf0);
		rxCase(8'hf0, 1'b1, 1'b1, 8'hf5);
		// Mode low must be cleared before the top bit turns into the error flag
		wr(ADDR_CTRL, 8'h70);
		wr(ADDR_PWR, 8'h40);
		rxCase(8'h70, 1'b0, 1'b0, 8'hf0);
		rd(ADDR_CTRL, 8'hf0);
		wr(ADDR_CTRL, 8'h70);
		rd(ADDR_CTRL, 8'h70);
		wr(ADDR_PWR, 8'h00);
		rd(ADDR_CTRL, 8'h70);
		end_sim();
	end
endmodule : spc_serial_port_bench
